// ---- ofd_pkg.sv ----
// Constants, types and register map of the operand field decoder.
// Assumes a single clock domain with a synchronous active-low reset.
// Overview of operation
// - Access bit zero addresses the access region; one uses the bank select register.
// - Three-bit bit number selects exactly one of bits zero to seven.
// - Destination bit zero writes the working register, one the file register.
// - File field is an 8-bit address or a 2-bit pointer designator.
// - Register move carries 12-bit source and 12-bit destination addresses.
// - Literal is extracted as 4, 8, 12 or 20 bits by format.
// - Table mode: unchanged, post-increment, post-decrement or pre-increment pointer.
// - Fast select one saves or restores shadow registers; zero leaves them.
// - Table access uses a 21-bit program pointer and an 8-bit latch.
// - Branch operand is signed displacement if relative, else absolute target.
// - Don't-care encoding bits never influence the decoded result.
// - Indexed offsets are 7-bit values added to a pointer.
// - Five arithmetic status flags are kept and may be updated.
// - Second words start with four ones and run alone as no-operation.
package ofd_pkg;
	localparam int ADDR_W = 8;
	localparam logic [7:0] OFF_INSTR = 8'h00;
	localparam logic [7:0] OFF_BANK = 8'h04;
	localparam logic [7:0] OFF_STATUS = 8'h08;
	localparam logic [7:0] OFF_RAMADDR = 8'h0c;
	localparam logic [7:0] OFF_LITERAL = 8'h10;
	localparam logic [7:0] OFF_BRANCH = 8'h14;
	localparam logic [7:0] OFF_MOVE = 8'h18;
	localparam logic [7:0] OFF_MISC = 8'h1c;
	localparam logic [7:0] OFF_FLAGS = 8'h20;
	localparam logic [7:0] OFF_PROGRAM_TABLE_POINTER = 8'h24;
	localparam logic [7:0] OFF_TBLLAT = 8'h28;
	localparam logic [7:0] OFF_IPTR = 8'h2c;
	localparam logic [3:0] RST_BANK = 4'h0;
	localparam logic [4:0] RST_FLAGS = 5'h00;
	localparam logic [20:0] RST_PROGRAM_TABLE_POINTER = 21'h000000;
	localparam logic [7:0] RST_TBLLAT = 8'h00;
	localparam logic [11:0] RST_IPTR = 12'h000;
	localparam logic [7:0] ACCESS_SPLIT = 8'h80;
	localparam logic [3:0] ACCESS_HIGH_BANK = 4'hf;
	localparam logic [3:0] SECOND_WORD_TAG = 4'hf;
	localparam logic [1:0] RESP_OKAY = 2'b00;
	localparam logic [1:0] RESP_SLVERR = 2'b10;
	typedef enum logic [1:0] {TBL_KEEP = 2'b00, TBL_POSTINC = 2'b01, TBL_POSTDEC = 2'b10,
		TBL_PREINC = 2'b11} ofd_tbl_mode_t;
	typedef enum logic [3:0] {FMT_NOP = 4'h0, FMT_BYTE = 4'h1, FMT_BIT = 4'h2, FMT_LIT8 = 4'h3,
		FMT_MOVE = 4'h4, FMT_LFSR = 4'h5, FMT_BRA_REL = 4'h6, FMT_BRA_ABS = 4'h7,
		FMT_TABLE = 4'h8, FMT_RETURN = 4'h9, FMT_INDEXED = 4'ha, FMT_BANKSEL = 4'hb}
		ofd_fmt_t;
	typedef enum logic [1:0] {ST_FIRST = 2'b01, ST_SECOND = 2'b10} ofd_state_t;
endpackage

// ---- ofd_field_if.sv ----
// Decoded operand fields of one instruction word, from extractor to top.
// Assumes the extractor is purely combinational.
`timescale 1ns/10ps
`default_nettype none
interface ofd_field_if;
	import ofd_pkg::*;
	ofd_fmt_t fmt;
	logic two_word;
	logic access_bit;
	logic dest_bit;
	logic [2:0] bit_num;
	logic [7:0] file_addr;
	logic [1:0] ptr_sel;
	logic [20:0] rel_disp;
	logic fast_sel;
	ofd_tbl_mode_t tbl_mode;
	logic tbl_write;
	logic [6:0] idx_src;
	logic idx_pair;
	modport extract (output fmt, two_word, access_bit, dest_bit, bit_num, file_addr, ptr_sel,
		rel_disp, fast_sel, tbl_mode, tbl_write, idx_src, idx_pair);
	modport user (input fmt, two_word, access_bit, dest_bit, bit_num, file_addr, ptr_sel,
		rel_disp, fast_sel, tbl_mode, tbl_write, idx_src, idx_pair);
endinterface
`default_nettype wire

// ---- ofd_field_extract.sv ----
// Combinational split of a first instruction word into its operand fields.
// Assumes the word is stable while the top samples the interface.
`timescale 1ns/10ps
`default_nettype none
module ofd_field_extract (
	// Instruction word
	input wire logic [15:0] word,
	// Decoded fields
	ofd_field_if.extract fld
);
	import ofd_pkg::*;
	always_comb
	begin
		fld.fmt = FMT_NOP;
		fld.two_word = 1'b0;
		fld.access_bit = word[8];
		fld.dest_bit = word[9];
		fld.bit_num = word[11:9];
		fld.file_addr = word[7:0];
		fld.ptr_sel = word[5:4];
		fld.rel_disp = {{13{word[7]}}, word[7:0]};
		fld.fast_sel = word[0];
		fld.tbl_mode = ofd_tbl_mode_t'(word[1:0]);
		fld.tbl_write = word[2];
		fld.idx_src = word[6:0];
		fld.idx_pair = word[7];
		casez (word[15:8])
			8'b0000_0000:
			begin
				if (word[7:3] == 5'b0000_1)
					fld.fmt = FMT_TABLE;
				else if (word[7:1] == 7'b0001_001 || word[7:1] == 7'b0001_000)
					fld.fmt = FMT_RETURN;
			end
			8'b0000_0001: fld.fmt = FMT_BANKSEL;
			8'b0000_001?, 8'b0000_01??, 8'b0001_????, 8'b0010_????, 8'b0011_????,
			8'b0100_????, 8'b0101_????, 8'b0110_????: fld.fmt = FMT_BYTE;
			8'b0000_1???: fld.fmt = FMT_LIT8;
			8'b0111_????, 8'b100?_????, 8'b1010_????, 8'b1011_????: fld.fmt = FMT_BIT;
			8'b1100_????:
			begin
				fld.fmt = FMT_MOVE;
				fld.two_word = 1'b1;
			end
			8'b1101_????:
			begin
				fld.fmt = FMT_BRA_REL;
				fld.rel_disp = {{10{word[10]}}, word[10:0]};
			end
			8'b1110_0???: fld.fmt = FMT_BRA_REL;
			8'b1110_110?, 8'b1110_1111:
			begin
				fld.fmt = FMT_BRA_ABS;
				fld.two_word = 1'b1;
			end
			8'b1110_1110:
			begin
				fld.fmt = (word[7:6] == 2'b00) ? FMT_LFSR : FMT_NOP;
				fld.two_word = (word[7:6] == 2'b00);
			end
			8'b1110_1011:
			begin
				fld.fmt = FMT_INDEXED;
				fld.two_word = 1'b1;
			end
			default: fld.fmt = FMT_NOP;
		endcase
	end
endmodule
`default_nettype wire

// ---- ofd_status_flags.sv ----
// Five arithmetic status flags, written by software and updated by the datapath.
// Assumes update inputs come from logic on the same clock.
`timescale 1ns/10ps
`default_nettype none
module ofd_status_flags (
	// Clock and reset
	input wire logic aclk,
	input wire logic aresetn,
	// Software write
	input wire logic sw_we,
	input wire logic [4:0] sw_data,
	// Datapath update: carry, digit carry, zero, overflow, negative
	input wire logic [4:0] hw_mask,
	input wire logic [4:0] hw_value,
	// Flag state
	output logic [4:0] flags
);
	import ofd_pkg::*;
	logic [4:0] flags_q;
	logic [4:0] flags_d;
	always_comb
	begin
		flags_d = sw_we ? sw_data : flags_q;
		// A datapath update in the same cycle as a software write wins per bit
		flags_d = (flags_d & ~hw_mask) | (hw_value & hw_mask);
	end
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
			flags_q <= RST_FLAGS;
		else
			flags_q <= flags_d;
	end
	assign flags = flags_q;
endmodule
`default_nettype wire

// ---- ofd_top.sv ----
// Operand field decoder: instruction words in over AXI4-Lite, decoded fields out.
// Assumes a single master with one write and one read outstanding at most.
//
// The address map and the AXI4-Lite slave port are this design's own decisions.
`timescale 1ns/10ps
`default_nettype none
module ofd_top (
	// Clock and reset
	input wire logic aclk,
	input wire logic aresetn,
	// AXI4-Lite write address
	input wire logic [31:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	// AXI4-Lite write data
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	// AXI4-Lite write response
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	// AXI4-Lite read address
	input wire logic [31:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	// AXI4-Lite read data
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	// Decoded operands to the datapath
	output logic decode_valid,
	output ofd_pkg::ofd_fmt_t decode_format,
	output logic [11:0] ram_address,
	output logic [7:0] bit_mask,
	output logic result_to_file,
	output logic [19:0] literal_value,
	output logic [20:0] branch_value,
	output logic branch_relative,
	// Shadow register control
	output logic shadow_save,
	output logic shadow_restore,
	// Program table access
	output logic table_request,
	output logic table_write,
	output logic [20:0] table_address,
	output logic [7:0] table_write_data,
	input wire logic [7:0] table_read_data,
	// Arithmetic status flags
	input wire logic [4:0] alu_flag_mask,
	input wire logic [4:0] alu_flag_value,
	output logic [4:0] status_flags
);
	import ofd_pkg::*;
	ofd_field_if fld ();
	ofd_state_t state_q;
	logic [31:0] awaddr_q;
	logic [31:0] wdata_q;
	logic [3:0] wstrb_q;
	logic aw_have_q;
	logic w_have_q;
	logic bvalid_q;
	logic [1:0] bresp_q;
	logic rvalid_q;
	logic [31:0] rdata_q;
	logic [1:0] rresp_q;
	logic wr_fire;
	logic [7:0] wr_off;
	logic wr_mapped;
	logic wr_mapped_ok;
	logic [15:0] word;
	logic [15:0] last_word_q;
	logic [15:0] first_q;
	ofd_fmt_t pend_fmt_q;
	logic [3:0] bank_q;
	logic [20:0] program_table_pointer_q;
	logic [7:0] tbllat_q;
	logic [11:0] iptr_q;
	logic instr_we;
	logic take_second;
	logic commit_one;
	ofd_fmt_t fmt_q;
	logic valid_q;
	logic [11:0] ram_addr_q;
	logic [7:0] bitmask_q;
	logic [7:0] bitmask_d;
	logic dest_q;
	logic access_q;
	logic [19:0] literal_q;
	logic [20:0] branch_q;
	logic rel_q;
	logic fast_q;
	logic save_q;
	logic restore_q;
	ofd_tbl_mode_t tbl_mode_q;
	logic [1:0] ptr_sel_q;
	logic [11:0] mv_src_q;
	logic [11:0] mv_dst_q;
	logic [6:0] idx_src_q;
	logic [6:0] idx_dst_q;
	logic treq_q;
	logic twr_q;
	logic [20:0] taddr_q;
	logic tread_pend_q;
	logic [11:0] file_addr_d;
	logic [20:0] program_table_pointer_next;
	logic [31:0] wr_merged;

	function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
		input logic [3:0] strb);
		logic [31:0] res;
		res = old;
		for (int i = 0; i < 4; i++)
			if (strb[i])
				res[8*i +: 8] = nw[8*i +: 8];
		return res;
	endfunction

	ofd_field_extract u_extract (
		.word(word),
		.fld(fld)
	);

	ofd_status_flags u_flags (
		.aclk(aclk),
		.aresetn(aresetn),
		.sw_we(wr_fire && wr_mapped_ok && wr_off == OFF_FLAGS),
		.sw_data(wr_merged[4:0]),
		.hw_mask(alu_flag_mask),
		.hw_value(alu_flag_value),
		.flags(status_flags)
	);

	// Write channel: address and data are taken in either order, then applied
	assign s_axi_awready = !aw_have_q;
	assign s_axi_wready = !w_have_q;
	assign wr_fire = aw_have_q && w_have_q && !bvalid_q;
	assign wr_off = awaddr_q[ADDR_W-1:0];
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			aw_have_q <= 1'b0;
			w_have_q <= 1'b0;
			awaddr_q <= 32'h00000000;
			wdata_q <= 32'h00000000;
			wstrb_q <= 4'h0;
		end
		else
		begin
			if (s_axi_awvalid && !aw_have_q)
			begin
				awaddr_q <= s_axi_awaddr;
				aw_have_q <= 1'b1;
			end
			else if (wr_fire)
				aw_have_q <= 1'b0;
			if (s_axi_wvalid && !w_have_q)
			begin
				wdata_q <= s_axi_wdata;
				wstrb_q <= s_axi_wstrb;
				w_have_q <= 1'b1;
			end
			else if (wr_fire)
				w_have_q <= 1'b0;
		end
	end

	always_comb
	begin
		unique case (wr_off)
			OFF_INSTR, OFF_BANK, OFF_FLAGS, OFF_PROGRAM_TABLE_POINTER, OFF_TBLLAT, OFF_IPTR: wr_mapped = 1'b1;
			default: wr_mapped = awaddr_q[31:ADDR_W] == '0 && 1'b0;
		endcase
	end
	assign wr_mapped_ok = wr_mapped && awaddr_q[31:ADDR_W] == '0;

	always_comb
	begin
		unique case (wr_off)
			OFF_INSTR: wr_merged = merge({16'h0000, last_word_q}, wdata_q, wstrb_q);
			OFF_BANK: wr_merged = merge({28'h0000000, bank_q}, wdata_q, wstrb_q);
			OFF_FLAGS: wr_merged = merge({27'h0000000, status_flags}, wdata_q, wstrb_q);
			OFF_PROGRAM_TABLE_POINTER: wr_merged = merge({11'h000, program_table_pointer_q}, wdata_q, wstrb_q);
			OFF_TBLLAT: wr_merged = merge({24'h000000, tbllat_q}, wdata_q, wstrb_q);
			OFF_IPTR: wr_merged = merge({20'h00000, iptr_q}, wdata_q, wstrb_q);
			default: wr_merged = 32'h00000000;
		endcase
	end

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			bvalid_q <= 1'b0;
			bresp_q <= RESP_OKAY;
		end
		else if (wr_fire)
		begin
			bvalid_q <= 1'b1;
			bresp_q <= wr_mapped_ok ? RESP_OKAY : RESP_SLVERR;
		end
		else if (s_axi_bready)
			bvalid_q <= 1'b0;
	end
	assign s_axi_bvalid = bvalid_q;
	assign s_axi_bresp = bresp_q;

	// Software-written configuration
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			bank_q <= RST_BANK;
			iptr_q <= RST_IPTR;
		end
		else if (wr_fire && wr_mapped_ok && wr_off == OFF_BANK)
			bank_q <= wr_merged[3:0];
		else if (wr_fire && wr_mapped_ok && wr_off == OFF_IPTR)
			iptr_q <= wr_merged[11:0];
	end

	// Instruction word intake and two-word pairing
	assign instr_we = wr_fire && wr_mapped_ok && wr_off == OFF_INSTR;
	assign word = wr_merged[15:0];
	assign take_second = state_q == ST_SECOND && word[15:12] == SECOND_WORD_TAG;
	assign commit_one = instr_we && !take_second && !fld.two_word;
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			state_q <= ST_FIRST;
			first_q <= 16'h0000;
			pend_fmt_q <= FMT_NOP;
			last_word_q <= 16'h0000;
		end
		else if (instr_we)
		begin
			last_word_q <= word;
			// A first word not followed by its tagged partner is dropped
			if (!take_second && fld.two_word)
			begin
				state_q <= ST_SECOND;
				first_q <= word;
				pend_fmt_q <= fld.fmt;
			end
			else
				state_q <= ST_FIRST;
		end
	end

	// Bank or access-region address of the file operand
	always_comb
	begin
		if (fld.access_bit)
			file_addr_d = {bank_q, fld.file_addr};
		else if (fld.file_addr < ACCESS_SPLIT)
			file_addr_d = {4'h0, fld.file_addr};
		else
			file_addr_d = {ACCESS_HIGH_BANK, fld.file_addr};
	end

	for (genvar i = 0; i < 8; i++)
	begin : g_mask
		assign bitmask_d[i] = fld.bit_num == 3'(i);
	end

	// Decoded result registers
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			valid_q <= 1'b0;
			fmt_q <= FMT_NOP;
			ram_addr_q <= 12'h000;
			bitmask_q <= 8'h00;
			dest_q <= 1'b0;
			access_q <= 1'b0;
			literal_q <= 20'h00000;
			branch_q <= 21'h000000;
			rel_q <= 1'b0;
			fast_q <= 1'b0;
			save_q <= 1'b0;
			restore_q <= 1'b0;
			tbl_mode_q <= TBL_KEEP;
			ptr_sel_q <= 2'b00;
			mv_src_q <= 12'h000;
			mv_dst_q <= 12'h000;
			idx_src_q <= 7'h00;
			idx_dst_q <= 7'h00;
		end
		else
		begin
			valid_q <= commit_one || (instr_we && take_second);
			save_q <= 1'b0;
			restore_q <= 1'b0;
			if (instr_we && take_second)
			begin
				fmt_q <= pend_fmt_q;
				unique case (pend_fmt_q)
					FMT_MOVE:
					begin
						mv_src_q <= first_q[11:0];
						mv_dst_q <= word[11:0];
						ram_addr_q <= first_q[11:0];
					end
					FMT_BRA_ABS:
					begin
						literal_q <= {word[11:0], first_q[7:0]};
						branch_q <= {1'b0, word[11:0], first_q[7:0]};
						rel_q <= 1'b0;
						fast_q <= first_q[9] ? 1'b0 : first_q[8];
						save_q <= !first_q[9] && first_q[8];
					end
					FMT_LFSR:
					begin
						ptr_sel_q <= first_q[5:4];
						literal_q <= {8'h00, first_q[3:0], word[7:0]};
					end
					FMT_INDEXED:
					begin
						idx_src_q <= first_q[6:0];
						ram_addr_q <= iptr_q + {5'h00, first_q[6:0]};
						if (first_q[7])
						begin
							idx_dst_q <= word[6:0];
							mv_dst_q <= iptr_q + {5'h00, word[6:0]};
						end
						else
							mv_dst_q <= word[11:0];
					end
					default: ;
				endcase
			end
			else if (commit_one)
			begin
				fmt_q <= fld.fmt;
				unique case (fld.fmt)
					FMT_BYTE:
					begin
						ram_addr_q <= file_addr_d;
						access_q <= fld.access_bit;
						dest_q <= fld.dest_bit;
					end
					FMT_BIT:
					begin
						ram_addr_q <= file_addr_d;
						access_q <= fld.access_bit;
						bitmask_q <= bitmask_d;
					end
					FMT_LIT8: literal_q <= {12'h000, word[7:0]};
					FMT_BANKSEL: literal_q <= {16'h0000, word[3:0]};
					FMT_BRA_REL:
					begin
						branch_q <= fld.rel_disp;
						rel_q <= 1'b1;
					end
					FMT_RETURN:
					begin
						fast_q <= fld.fast_sel;
						restore_q <= fld.fast_sel;
					end
					FMT_TABLE: tbl_mode_q <= fld.tbl_mode;
					default: ;
				endcase
			end
		end
	end

	// Table pointer stepping and latch exchange
	always_comb
	begin
		unique case (fld.tbl_mode)
			TBL_POSTINC, TBL_PREINC: program_table_pointer_next = program_table_pointer_q + 21'h000001;
			TBL_POSTDEC: program_table_pointer_next = program_table_pointer_q - 21'h000001;
			default: program_table_pointer_next = program_table_pointer_q;
		endcase
	end
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			program_table_pointer_q <= RST_PROGRAM_TABLE_POINTER;
			tbllat_q <= RST_TBLLAT;
			treq_q <= 1'b0;
			twr_q <= 1'b0;
			taddr_q <= 21'h000000;
			tread_pend_q <= 1'b0;
		end
		else
		begin
			treq_q <= 1'b0;
			tread_pend_q <= 1'b0;
			// Read data arrives one cycle after the request
			if (tread_pend_q)
				tbllat_q <= table_read_data;
			else if (wr_fire && wr_mapped_ok && wr_off == OFF_TBLLAT)
				tbllat_q <= wr_merged[7:0];
			if (commit_one && fld.fmt == FMT_TABLE)
			begin
				treq_q <= 1'b1;
				twr_q <= fld.tbl_write;
				tread_pend_q <= !fld.tbl_write;
				taddr_q <= (fld.tbl_mode == TBL_PREINC) ? program_table_pointer_next : program_table_pointer_q;
				program_table_pointer_q <= program_table_pointer_next;
			end
			else if (wr_fire && wr_mapped_ok && wr_off == OFF_PROGRAM_TABLE_POINTER)
				program_table_pointer_q <= wr_merged[20:0];
		end
	end

	// Read channel: answer one cycle after the address is taken
	assign s_axi_arready = !rvalid_q;
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			rvalid_q <= 1'b0;
			rdata_q <= 32'h00000000;
			rresp_q <= RESP_OKAY;
		end
		else if (s_axi_arvalid && !rvalid_q)
		begin
			rvalid_q <= 1'b1;
			rresp_q <= s_axi_araddr[31:ADDR_W] == '0 ? RESP_OKAY : RESP_SLVERR;
			unique case (s_axi_araddr[ADDR_W-1:0])
				OFF_INSTR: rdata_q <= {16'h0000, last_word_q};
				OFF_BANK: rdata_q <= {28'h0000000, bank_q};
				OFF_STATUS: rdata_q <= {24'h000000, access_q, dest_q, rel_q,
					state_q == ST_SECOND, fmt_q};
				OFF_RAMADDR: rdata_q <= {8'h00, bitmask_q, 4'h0, ram_addr_q};
				OFF_LITERAL: rdata_q <= {12'h000, literal_q};
				OFF_BRANCH: rdata_q <= {rel_q, 10'h000, branch_q};
				OFF_MOVE: rdata_q <= {4'h0, mv_dst_q, 4'h0, mv_src_q};
				OFF_MISC: rdata_q <= {1'b0, idx_dst_q, 1'b0, idx_src_q, 6'h00, ptr_sel_q,
					2'b00, tbl_mode_q, 3'b000, fast_q};
				OFF_FLAGS: rdata_q <= {27'h0000000, status_flags};
				OFF_PROGRAM_TABLE_POINTER: rdata_q <= {11'h000, program_table_pointer_q};
				OFF_TBLLAT: rdata_q <= {24'h000000, tbllat_q};
				OFF_IPTR: rdata_q <= {20'h00000, iptr_q};
				default:
				begin
					rdata_q <= 32'h00000000;
					rresp_q <= RESP_SLVERR;
				end
			endcase
		end
		else if (s_axi_rready)
			rvalid_q <= 1'b0;
	end
	assign s_axi_rvalid = rvalid_q;
	assign s_axi_rdata = rdata_q;
	assign s_axi_rresp = rresp_q;

	assign decode_valid = valid_q;
	assign decode_format = fmt_q;
	assign ram_address = ram_addr_q;
	assign bit_mask = bitmask_q;
	assign result_to_file = dest_q;
	assign literal_value = literal_q;
	assign branch_value = branch_q;
	assign branch_relative = rel_q;
	assign shadow_save = save_q;
	assign shadow_restore = restore_q;
	assign table_request = treq_q;
	assign table_write = twr_q;
	assign table_address = taddr_q;
	assign table_write_data = tbllat_q;
endmodule
`default_nettype wire

// ---- ofd_top_fix_note_unused.sv ----
`timescale 1ns/10ps

// ---- ofd_properties.sv ----
// Concurrent checks on the operand field decoder's top-level ports.
// Assumes binding to ofd_top; one clock, synchronous active-low reset.
`timescale 1ns/10ps
`default_nettype none
module ofd_checker (
	// Clock and reset
	input wire logic aclk,
	input wire logic aresetn,
	// Register bus
	input wire logic s_axi_awvalid,
	input wire logic s_axi_awready,
	input wire logic s_axi_wvalid,
	input wire logic s_axi_wready,
	input wire logic [1:0] s_axi_bresp,
	input wire logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic s_axi_arvalid,
	input wire logic s_axi_arready,
	input wire logic [31:0] s_axi_rdata,
	input wire logic s_axi_rvalid,
	input wire logic s_axi_rready,
	// Decoded outputs
	input wire logic decode_valid,
	input wire ofd_pkg::ofd_fmt_t decode_format,
	input wire logic [7:0] bit_mask,
	input wire logic result_to_file,
	input wire logic shadow_save,
	input wire logic shadow_restore,
	input wire logic table_request,
	// Status flags
	input wire logic [4:0] alu_flag_mask,
	input wire logic [4:0] alu_flag_value,
	input wire logic [4:0] status_flags
);
	import ofd_pkg::*;
	default clocking @(posedge aclk); endclocking
	default disable iff (!aresetn);
	property p_b_hold;
		s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp);
	endproperty
	a_b_hold: assert property (p_b_hold) else $error("write response not held");
	property p_r_hold;
		s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata);
	endproperty
	a_r_hold: assert property (p_r_hold) else $error("read data not held");
	property p_rd_lat;
		s_axi_arvalid && s_axi_arready |=> s_axi_rvalid;
	endproperty
	a_rd_lat: assert property (p_rd_lat) else $error("read answer late");
	// Both channels taken at one edge: response two edges later
	property p_wr_lat;
		s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready |-> ##2 s_axi_bvalid;
	endproperty
	a_wr_lat: assert property (p_wr_lat) else $error("write answer late");
	property p_dv_pulse;
		decode_valid |=> !decode_valid;
	endproperty
	a_dv_pulse: assert property (p_dv_pulse) else $error("decode strobe too long");
	property p_bit_onehot;
		decode_valid && decode_format == FMT_BIT |-> $onehot(bit_mask);
	endproperty
	a_bit_onehot: assert property (p_bit_onehot) else $error("bit select not one-hot");
	property p_shadow;
		shadow_save |-> !shadow_restore;
	endproperty
	a_shadow: assert property (p_shadow) else $error("shadow save and restore together");
	property p_nop_quiet;
		decode_valid && decode_format == FMT_NOP |-> !table_request && !shadow_save
			&& !shadow_restore;
	endproperty
	a_nop_quiet: assert property (p_nop_quiet) else $error("lone second word acted");
	property p_flags;
		alu_flag_mask == 5'h1f |=> status_flags == $past(alu_flag_value);
	endproperty
	a_flags: assert property (p_flags) else $error("flags not loaded");
	property p_dest_keep;
		!decode_valid |-> $stable(result_to_file);
	endproperty
	a_dest_keep: assert property (p_dest_keep) else $error("destination changed alone");
endmodule
bind ofd_top ofd_checker u_chk (.aclk, .aresetn, .s_axi_awvalid, .s_axi_awready, .s_axi_wvalid,
	.s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_arvalid, .s_axi_arready,
	.s_axi_rdata, .s_axi_rvalid, .s_axi_rready, .decode_valid, .decode_format, .bit_mask,
	.result_to_file, .shadow_save, .shadow_restore, .table_request, .alu_flag_mask,
	.alu_flag_value, .status_flags);
`default_nettype wire

// ---- tb_top.sv ----
// Self-checking bench: instruction words in over the register bus, fields read back.
// Assumes the checker is bound from its own file.
`timescale 1ns/10ps
`default_nettype none
module tb_top;
	import ofd_pkg::*;
	logic aclk, aresetn, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
	logic s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
	logic [31:0] s_axi_awaddr, s_axi_wdata, s_axi_araddr, s_axi_rdata;
	logic [3:0] s_axi_wstrb;
	logic [1:0] s_axi_bresp, s_axi_rresp;
	logic decode_valid, result_to_file;
	ofd_fmt_t decode_format;
	logic [11:0] ram_address;
	logic [7:0] table_read_data;
	logic [4:0] alu_flag_mask, alu_flag_value, status_flags;
	logic [43:0] rows [6];
	int fail_count, num_checks, dv_n, n0;
	ofd_top uut (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
		.s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
		.s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
		.s_axi_rready, .decode_valid, .decode_format, .ram_address, .bit_mask(),
		.result_to_file, .literal_value(), .branch_value(), .branch_relative(), .shadow_save(),
		.shadow_restore(), .table_request(), .table_write(), .table_address(),
		.table_write_data(), .table_read_data, .alu_flag_mask, .alu_flag_value, .status_flags);
	initial
	begin
		aclk = 0;
		forever #2 aclk = ~aclk;
	end
	always @(posedge aclk)
		if (decode_valid === 1'b1)
			dv_n <= dv_n + 1;
	task automatic results();
		$display("Checks made %0d, mismatches %0d", num_checks, fail_count);
		if (fail_count == 0 && num_checks > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask
	task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
		num_checks++;
		if (e !== g)
		begin
			fail_count++;
			$display("Error %s expected %h seen %h", nm, e, g);
		end
	endtask
	// Answer ready goes up with the request; each channel drops once taken
	task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
		s_axi_awaddr <= {24'h0, a};
		s_axi_awvalid <= 1'b1;
		s_axi_wdata <= d;
		s_axi_wvalid <= 1'b1;
		s_axi_bready <= 1'b1;
		do
		begin
			@(posedge aclk);
			if (s_axi_awvalid && s_axi_awready)
				s_axi_awvalid <= 1'b0;
			if (s_axi_wvalid && s_axi_wready)
				s_axi_wvalid <= 1'b0;
		end
		while (!s_axi_bvalid);
		chk($sformatf("bresp %h", a), {30'h0, er}, {30'h0, s_axi_bresp});
		s_axi_bready <= 1'b0;
		@(posedge aclk);
	endtask
	task automatic rd(input logic [7:0] a, input logic [31:0] e, input logic [1:0] er);
		s_axi_araddr <= {24'h0, a};
		s_axi_arvalid <= 1'b1;
		s_axi_rready <= 1'b1;
		do
		begin
			@(posedge aclk);
			if (s_axi_arvalid && s_axi_arready)
				s_axi_arvalid <= 1'b0;
		end
		while (!s_axi_rvalid);
		chk($sformatf("reg %h", a), e, s_axi_rdata);
		chk($sformatf("rresp %h", a), {30'h0, er}, {30'h0, s_axi_rresp});
		s_axi_rready <= 1'b0;
		@(posedge aclk);
	endtask
	// Whole run is under two hundred cycles; this margin only catches a hang
	initial
	begin
		repeat (5000) @(posedge aclk);
		fail_count++;
		results();
	end
	initial
	begin
		aresetn = 0;
		s_axi_awaddr = 0;
		s_axi_awvalid = 0;
		s_axi_wdata = 0;
		s_axi_wstrb = 4'hf;
		s_axi_wvalid = 0;
		s_axi_bready = 0;
		s_axi_araddr = 0;
		s_axi_arvalid = 0;
		s_axi_rready = 0;
		table_read_data = 8'h5a;
		alu_flag_mask = 0;
		alu_flag_value = 0;
		rows = '{44'h2412_00_012_01, 44'h2490_00_f90_01, 44'h2534_00_534_81,
			44'h2634_00_034_41, 44'h2755_00_555_c1, 44'h7a12_20_012_42};
		repeat (5) @(posedge aclk);
		aresetn <= 1'b1;
		rd(OFF_BANK, 32'h0, RESP_OKAY);
		rd(OFF_PROGRAM_TABLE_POINTER, 32'h0, RESP_OKAY);
		wr(OFF_BANK, 32'h5, RESP_OKAY);
		foreach (rows[i])
		begin
			wr(OFF_INSTR, {16'h0, rows[i][43:28]}, RESP_OKAY);
			rd(OFF_RAMADDR, {8'h0, rows[i][27:20], 4'h0, rows[i][19:8]}, RESP_OKAY);
			rd(OFF_STATUS, {24'h0, rows[i][7:0]}, RESP_OKAY);
			chk("result_to_file", {31'h0, rows[i][6]}, {31'h0, result_to_file});
		end
		n0 = dv_n;
		wr(OFF_INSTR, 32'hc123, RESP_OKAY);
		chk("held strobes", n0, dv_n);
		wr(OFF_INSTR, 32'hf456, RESP_OKAY);
		chk("pair strobes", n0 + 1, dv_n);
		chk("format", {28'h0, FMT_MOVE}, {28'h0, decode_format});
		rd(OFF_MOVE, 32'h0456_0123, RESP_OKAY);
		wr(OFF_INSTR, 32'hf0f0, RESP_OKAY);
		chk("lone strobes", n0 + 2, dv_n);
		chk("format", {28'h0, FMT_NOP}, {28'h0, decode_format});
		wr(OFF_INSTR, 32'hc777, RESP_OKAY);
		wr(OFF_INSTR, 32'h2634, RESP_OKAY);
		chk("ram_address", 32'h034, {20'h0, ram_address});
		rd(OFF_MOVE, 32'h0456_0123, RESP_OKAY);
		wr(OFF_PROGRAM_TABLE_POINTER, 32'hffff_ffff, RESP_OKAY);
		rd(OFF_PROGRAM_TABLE_POINTER, 32'h001f_ffff, RESP_OKAY);
		wr(OFF_TBLLAT, 32'hffff_ffff, RESP_OKAY);
		rd(OFF_TBLLAT, 32'h0000_00ff, RESP_OKAY);
		wr(OFF_INSTR, 32'h0009, RESP_OKAY);
		rd(OFF_TBLLAT, 32'h5a, RESP_OKAY);
		rd(OFF_PROGRAM_TABLE_POINTER, 32'h0, RESP_OKAY);
		rd(OFF_MISC, 32'h10, RESP_OKAY);
		wr(OFF_INSTR, 32'hd7ff, RESP_OKAY);
		rd(OFF_BRANCH, 32'h801f_ffff, RESP_OKAY);
		wr(OFF_INSTR, 32'h0e12, RESP_OKAY);
		rd(OFF_LITERAL, 32'h12, RESP_OKAY);
		wr(OFF_FLAGS, 32'h0a, RESP_OKAY);
		rd(OFF_FLAGS, 32'h0a, RESP_OKAY);
		alu_flag_mask <= 5'h1f;
		alu_flag_value <= 5'h15;
		@(posedge aclk);
		alu_flag_mask <= 5'h0;
		rd(OFF_FLAGS, 32'h15, RESP_OKAY);
		wr(OFF_STATUS, 32'h1, RESP_SLVERR);
		wr(8'h30, 32'h1, RESP_SLVERR);
		rd(8'h30, 32'h0, RESP_SLVERR);
		aresetn <= 1'b0;
		repeat (5) @(posedge aclk);
		aresetn <= 1'b1;
		rd(OFF_BANK, 32'h0, RESP_OKAY);
		chk("ram_address", 32'h0, {20'h0, ram_address});
		chk("status_flags", 32'h0, {27'h0, status_flags});
		results();
	end
endmodule
`default_nettype wire
